/* verilog/tmr_pkg.sv */
// constants, types and register map of the three-channel 16-bit timer
package tmr_pkg;
  localparam int NCH = 3;
  localparam int CW = 16;
  // per-channel offsets, channel base is channel number times stride
  localparam logic [6:0] CH_STRIDE = 7'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_IOCTL = 5'h04;
  localparam logic [4:0] OFF_CNT = 5'h08;
  localparam logic [4:0] OFF_CNT_HI = 5'h0C;
  localparam logic [4:0] OFF_CNT_LO = 5'h10;
  localparam logic [4:0] OFF_GRA = 5'h14;
  localparam logic [4:0] OFF_GRB = 5'h18;
  // shared registers
  localparam logic [6:0] OFF_MODE = 7'h60;
  localparam logic [6:0] OFF_SYNC = 7'h64;
  localparam logic [6:0] OFF_START = 7'h68;
  localparam logic [6:0] OFF_STAT = 7'h6C;
  localparam logic [6:0] OFF_MASK = 7'h70;
  localparam logic [1:0] GLOBAL_SEL = 2'h3;
  // field positions
  localparam int IO_CAP_A = 0;
  localparam int IO_CAP_B = 1;
  localparam int MODE_QUAD = 3;
  localparam int ST_A = 0;
  localparam int ST_B = 1;
  localparam int ST_WRAP = 2;
  localparam int ST_PER_CH = 3;
  localparam int QUAD_CH = 2;
  // clear source encodings
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] IOCTL_RST = 2'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [2:0] START_RST = 3'h0;
  localparam logic [8:0] STAT_RST = 9'h000;
  localparam logic [8:0] MASK_RST = 9'h000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_T1 = 4'h2,
    BUS_T2 = 4'h4,
    BUS_T3 = 4'h8
  } tmr_bus_t;
endpackage

/* verilog/tmr_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tmr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change is accepted only once the second and third stages agree
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      level <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (s2_q[i] == s3_q[i])
          level[i] <= s3_q[i];
  end
endmodule

/* verilog/tmr_core.sv */
// three-channel 16-bit timer with bus contention arbitration, AHB-Lite slave
`timescale 1ns/1ps
module tmr_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [tmr_pkg::NCH-1:0] count_pulse,
  input wire logic [tmr_pkg::NCH-1:0] capture_a_pin,
  input wire logic [tmr_pkg::NCH-1:0] capture_b_pin,
  input wire logic quad_a_pin,
  input wire logic quad_b_pin,
  output logic [tmr_pkg::NCH-1:0] pwm_out,
  output logic [tmr_pkg::NCH-1:0] match_a_out,
  output logic [tmr_pkg::NCH-1:0] match_b_out,
  output logic irq
);
  import tmr_pkg::*;

  tmr_bus_t st_q;
  tmr_bus_t st_d;
  logic [6:0] addr_q;
  logic wr_q;
  logic ok_q;
  logic [1:0] ctrl_q [NCH];
  logic [1:0] ioc_q [NCH];
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] gra_q [NCH];
  logic [CW-1:0] grb_q [NCH];
  logic [3:0] mode_q;
  logic [2:0] sync_q;
  logic [2:0] start_q;
  logic [8:0] stat_q;
  logic [8:0] mask_q;
  logic [7:0] pin_lvl;
  logic [7:0] pin_prev_q;
  logic [7:0] pin_rise;
  logic [31:0] rdata_d;
  logic accept;
  logic wr_t3;
  logic [4:0] off;
  logic [1:0] csel;
  logic quad_step;
  logic quad_up;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] wr_w;
  logic [NCH-1:0] wr_hi;
  logic [NCH-1:0] wr_lo;
  logic [NCH-1:0] byte_pend;
  logic [NCH-1:0] wr_gra;
  logic [NCH-1:0] wr_grb;
  logic [NCH-1:0] pulse;
  logic [NCH-1:0] up;
  logic [NCH-1:0] mraw_a;
  logic [NCH-1:0] mraw_b;
  logic [NCH-1:0] ma;
  logic [NCH-1:0] mb;
  logic [NCH-1:0] cap_a;
  logic [NCH-1:0] cap_b;
  logic [NCH-1:0] clr_own;
  logic [NCH-1:0] clear;
  logic [NCH-1:0] wrap;
  logic [NCH-1:0] ld;
  logic [CW-1:0] load_val;
  logic [8:0] stat_set;

  tmr_sync #(
    .WIDTH(8)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pin({quad_b_pin, quad_a_pin, capture_b_pin, capture_a_pin}),
    .level(pin_lvl)
  );

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pin_prev_q <= '0;
    else
      pin_prev_q <= pin_lvl;
  end

  assign pin_rise = pin_lvl & ~pin_prev_q;

  // quadrature decode, both edges of both inputs; simultaneous changes are ignored
  always_comb
  begin
    quad_step = (pin_lvl[6] ^ pin_prev_q[6]) ^ (pin_lvl[7] ^ pin_prev_q[7]);
    if (pin_lvl[6] != pin_prev_q[6])
      quad_up = (pin_lvl[6] == pin_lvl[7]);
    else
      quad_up = (pin_lvl[7] != pin_lvl[6]);
  end

  // bus cycle: address phase, then T1, T2, T3 with the commit at T3
  assign accept = hsel & hready & htrans[1];

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      BUS_IDLE: st_d = accept ? BUS_T1 : BUS_IDLE;
      BUS_T1: st_d = BUS_T2;
      BUS_T2: st_d = BUS_T3;
      BUS_T3: st_d = accept ? BUS_T1 : BUS_IDLE;
      default: st_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= BUS_IDLE;
      addr_q <= '0;
      wr_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (accept)
      begin
        addr_q <= haddr[6:0];
        wr_q <= hwrite;
        ok_q <= (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
      end
    end
  end

  assign hreadyout = (st_q != BUS_T1) && (st_q != BUS_T2);
  assign hresp = 1'b0;
  assign wr_t3 = (st_q == BUS_T3) & wr_q & ok_q;
  assign off = addr_q[4:0];
  assign csel = addr_q[6:5];

  // event and contention logic per channel
  always_comb
  begin
    load_val = '0;
    stat_set = '0;
    for (int c = 0; c < NCH; c++)
    begin
      hit[c] = ok_q && (csel == 2'(c));
      wr_w[c] = wr_t3 & hit[c] & (off == OFF_CNT);
      wr_hi[c] = wr_t3 & hit[c] & (off == OFF_CNT_HI);
      wr_lo[c] = wr_t3 & hit[c] & (off == OFF_CNT_LO);
      wr_gra[c] = wr_t3 & hit[c] & (off == OFF_GRA);
      wr_grb[c] = wr_t3 & hit[c] & (off == OFF_GRB);
      // a byte write holds off counting in both its T2 and T3
      byte_pend[c] = wr_q & hit[c] & ((st_q == BUS_T2) | (st_q == BUS_T3))
                     & ((off == OFF_CNT_HI) | (off == OFF_CNT_LO));
      if (c == QUAD_CH && mode_q[MODE_QUAD])
      begin
        pulse[c] = start_q[c] & quad_step;
        up[c] = quad_up;
      end
      else
      begin
        pulse[c] = start_q[c] & count_pulse[c];
        up[c] = 1'b1;
      end
      // match fires as the count leaves the matching value
      mraw_a[c] = pulse[c] & (cnt_q[c] == gra_q[c])
                  & (mode_q[c] | ~ioc_q[c][IO_CAP_A]);
      mraw_b[c] = pulse[c] & (cnt_q[c] == grb_q[c])
                  & (mode_q[c] | ~ioc_q[c][IO_CAP_B]);
      ma[c] = mraw_a[c] & ~wr_gra[c] & ~(mode_q[c] & mraw_b[c]);
      mb[c] = mraw_b[c] & ~wr_grb[c] & ~(mode_q[c] & mraw_a[c]);
      cap_a[c] = pin_rise[c] & ioc_q[c][IO_CAP_A] & ~mode_q[c];
      cap_b[c] = pin_rise[NCH+c] & ioc_q[c][IO_CAP_B] & ~mode_q[c];
      clr_own[c] = ((ctrl_q[c] == CLR_A) & (ma[c] | cap_a[c]))
                   | ((ctrl_q[c] == CLR_B) & (mb[c] | cap_b[c]));
      wrap[c] = pulse[c] & (up[c] ? (cnt_q[c] == 16'hFFFF) : (cnt_q[c] == 16'h0000));
      if (wr_w[c])
        load_val = hwdata[15:0];
      else if (wr_hi[c])
        load_val = {hwdata[7:0], cnt_q[c][7:0]};
      else if (wr_lo[c])
        load_val = {cnt_q[c][15:8], hwdata[7:0]};
      stat_set[ST_PER_CH*c+ST_A] = ma[c] | cap_a[c];
      stat_set[ST_PER_CH*c+ST_B] = mb[c] | cap_b[c];
      stat_set[ST_PER_CH*c+ST_WRAP] = wrap[c];
    end
    for (int c = 0; c < NCH; c++)
    begin
      clear[c] = clr_own[c] | ((ctrl_q[c] == CLR_SYNC) & sync_q[c]
                 & |(clr_own & sync_q));
      // a synced write loads every synced counter with the same full value
      ld[c] = wr_w[c] | wr_hi[c] | wr_lo[c]
              | (sync_q[c] & |((wr_w | wr_hi | wr_lo) & sync_q));
    end
  end

  // counters: clear, then write, then count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      for (int c = 0; c < NCH; c++)
        cnt_q[c] <= CNT_RST;
    else
      for (int c = 0; c < NCH; c++)
        if (clear[c])
          cnt_q[c] <= CNT_RST;
        else if (ld[c])
          cnt_q[c] <= load_val;
        else if (pulse[c] & ~byte_pend[c])
          cnt_q[c] <= up[c] ? cnt_q[c] + 16'h0001 : cnt_q[c] - 16'h0001;
  end

  // compare/capture registers: capture wins over a CPU write
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      for (int c = 0; c < NCH; c++)
      begin
        gra_q[c] <= GR_RST;
        grb_q[c] <= GR_RST;
      end
    else
      for (int c = 0; c < NCH; c++)
      begin
        if (cap_a[c])
          gra_q[c] <= cnt_q[c];
        else if (wr_gra[c])
          gra_q[c] <= hwdata[15:0];
        if (cap_b[c])
          grb_q[c] <= cnt_q[c];
        else if (wr_grb[c])
          grb_q[c] <= hwdata[15:0];
      end
  end

  // control registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ctrl_q[c] <= CTRL_RST;
        ioc_q[c] <= IOCTL_RST;
      end
      mode_q <= MODE_RST;
      sync_q <= SYNC_RST;
      start_q <= START_RST;
      mask_q <= MASK_RST;
    end
    else if (wr_t3)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (hit[c] && off == OFF_CTRL)
          ctrl_q[c] <= hwdata[1:0];
        if (hit[c] && off == OFF_IOCTL)
          ioc_q[c] <= hwdata[1:0];
      end
      if (addr_q == OFF_MODE)
        mode_q <= hwdata[3:0];
      if (addr_q == OFF_SYNC)
        sync_q <= hwdata[2:0];
      if (addr_q == OFF_START)
        start_q <= hwdata[2:0];
      if (addr_q == OFF_MASK)
        mask_q <= hwdata[8:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      stat_q <= STAT_RST;
    else if (wr_t3 && addr_q == OFF_STAT)
      stat_q <= (stat_q & ~hwdata[8:0]) | stat_set;
    else
      stat_q <= stat_q | stat_set;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(stat_d_view() & mask_q);
  end

  function automatic logic [8:0] stat_d_view();
    stat_d_view = stat_q;
  endfunction

  // pwm level and match pulses
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_out <= '0;
      match_a_out <= '0;
      match_b_out <= '0;
    end
    else
    begin
      match_a_out <= ma;
      match_b_out <= mb;
      for (int c = 0; c < NCH; c++)
        if (mode_q[c] & ma[c])
          pwm_out[c] <= 1'b1;
        else if (mode_q[c] & mb[c])
          pwm_out[c] <= 1'b0;
    end
  end

  // read data sampled entering T3, so a capture in T3 is not seen
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (ok_q && csel != GLOBAL_SEL)
    begin
      for (int c = 0; c < NCH; c++)
        if (hit[c])
          unique case (off)
            OFF_CTRL: rdata_d = {30'h0, ctrl_q[c]};
            OFF_IOCTL: rdata_d = {30'h0, ioc_q[c]};
            OFF_CNT: rdata_d = {16'h0, cnt_q[c]};
            OFF_CNT_HI: rdata_d = {24'h0, cnt_q[c][15:8]};
            OFF_CNT_LO: rdata_d = {24'h0, cnt_q[c][7:0]};
            OFF_GRA: rdata_d = {16'h0, gra_q[c]};
            OFF_GRB: rdata_d = {16'h0, grb_q[c]};
            default: rdata_d = 32'h0000_0000;
          endcase
    end
    else if (ok_q)
      unique case (addr_q)
        OFF_MODE: rdata_d = {28'h0, mode_q};
        OFF_SYNC: rdata_d = {29'h0, sync_q};
        OFF_START: rdata_d = {29'h0, start_q};
        OFF_STAT: rdata_d = {23'h0, stat_q};
        OFF_MASK: rdata_d = {23'h0, mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hrdata <= '0;
    else if (st_q == BUS_T2 && !wr_q)
      hrdata <= rdata_d;
  end

  // checks
  sequence s_addr;
    accept;
  endsequence
  sequence s_three_states;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence
  sequence s_gra_read;
    st_q == BUS_T2 && !wr_q && hit[0] && off == OFF_GRA;
  endsequence

  AST_BUS_T3: assert property (@(posedge clock) disable iff (!nrst)
    s_addr |=> s_three_states)
    else $error("bus cycle not three states");
  AST_CLR_WINS: assert property (@(posedge clock) disable iff (!nrst)
    (clear[0] && wr_w[0]) |=> cnt_q[0] == 16'h0000)
    else $error("write beat counter clear");
  AST_WORD_WR: assert property (@(posedge clock) disable iff (!nrst)
    (wr_w[0] && !clear[0] && pulse[0]) |=> cnt_q[0] == $past(hwdata[15:0]))
    else $error("word write lost to increment");
  AST_BYTE_KEEP: assert property (@(posedge clock) disable iff (!nrst)
    (wr_hi[0] && !clear[0]) |=> cnt_q[0][7:0] == $past(cnt_q[0][7:0]))
    else $error("unwritten byte changed");
  AST_WR_NO_MATCH: assert property (@(posedge clock) disable iff (!nrst)
    wr_gra[0] |=> !match_a_out[0])
    else $error("match during compare write");
  AST_WRAP_FLAG: assert property (@(posedge clock) disable iff (!nrst)
    (wrap[0] && wr_w[0]) |=> stat_q[ST_WRAP] && cnt_q[0] == $past(hwdata[15:0]))
    else $error("wrap on write mishandled");
  AST_READ_PRE: assert property (@(posedge clock) disable iff (!nrst)
    s_gra_read ##1 cap_a[0] |=> hrdata[15:0] == $past(gra_q[0], 2))
    else $error("read saw captured value");
  AST_CAP_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    (cap_a[0] && ctrl_q[0] == CLR_A && pulse[0])
    |=> cnt_q[0] == 16'h0000 && gra_q[0] == $past(cnt_q[0]))
    else $error("capture clear mishandled");
  AST_CAP_OVER_WR: assert property (@(posedge clock) disable iff (!nrst)
    (cap_a[0] && wr_gra[0]) |=> gra_q[0] == $past(cnt_q[0]))
    else $error("write beat capture");
  AST_SYNC_LOAD: assert property (@(posedge clock) disable iff (!nrst)
    (wr_hi[0] && sync_q[0] && sync_q[1] && clear == 3'h0) |=> cnt_q[1] == cnt_q[0])
    else $error("synced counters differ");
  AST_PWM_NOCAP: assert property (@(posedge clock) disable iff (!nrst)
    (mode_q[0] && !wr_gra[0]) |=> gra_q[0] == $past(gra_q[0]))
    else $error("capture in pwm mode");
  AST_PWM_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    (mode_q[0] && mraw_a[0] && !mraw_b[0] && !wr_gra[0]) |=> pwm_out[0])
    else $error("pwm not set on A match");
endmodule

/* testbench/tmr_ahb_master.sv */
// cpu-side bus master model issuing single-word ahb-lite transfers
`timescale 1ns/1ps
module tmr_ahb_master (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import tmr_pkg::*;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end
  // one transfer; the slave decides the wait, so no cycle count is assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
    // released data lines must not keep showing the old word
    hwdata <= ~d;
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the timer: bus access, contention, modes, interrupt
`timescale 1ns/1ps
module testbench;
  import tmr_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} tmr_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] count_pulse = 3'h0;
  logic [2:0] cap_a = 3'h0;
  logic quad_a = 1'b0;
  logic quad_b = 1'b0;
  logic hsel, hwrite, hready, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] pwm_out;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  tmr_row_t rows[5];
  always #10 clock = ~clock;
  tmr_ahb_master u_tmr_ahb_master (.clock(clock), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  // capture_b pins stay idle: that path is left unexercised
  tmr_core u_tmr_core (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .count_pulse(count_pulse),
    .capture_a_pin(cap_a), .capture_b_pin(3'h0), .quad_a_pin(quad_a), .quad_b_pin(quad_b),
    .pwm_out(pwm_out), .match_a_out(), .match_b_out(), .irq(irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] ad(input int ch, input logic [6:0] off);
    return 32'(ch) * 32'h20 + {25'h0, off};
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_tmr_ahb_master.xfer(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_tmr_ahb_master.xfer(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // write with a channel 0 count pulse k edges in: 3 lands in T2, 4 in T3
  task automatic wrp(input logic [31:0] a, input logic [31:0] d, input int k);
    fork
      wr(a, d);
      begin
        repeat (k) @(posedge clock);
        count_pulse <= 3'h1;
        @(posedge clock);
        count_pulse <= 3'h0;
      end
    join
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clock);
      count_pulse <= 3'h1;
      @(posedge clock);
      count_pulse <= 3'h0;
    end
    repeat (3) @(posedge clock);
  endtask
  initial
  begin
    rows[0] = '{ad(0, 7'(OFF_CTRL)), 32'hFFFF_FFFF, 32'h0000_0003};
    rows[1] = '{ad(1, 7'(OFF_IOCTL)), 32'h0000_000F, 32'h0000_0003};
    rows[2] = '{ad(2, 7'(OFF_GRB)), 32'h1234_5678, 32'h0000_5678};
    rows[3] = '{ad(0, 7'(OFF_CNT)), 32'h0000_BEEF, 32'h0000_BEEF};
    rows[4] = '{32'h0000_007C, 32'h0000_000F, 32'h0000_0000};
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    $display("test rows done");
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    chk("hreadyout", {31'h0, hready}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    nrst <= 1'b1;
    rdc(ad(0, 7'(OFF_CTRL)), 32'h0);
    rdc(ad(0, 7'(OFF_CNT)), 32'h0);
    rdc(ad(2, 7'(OFF_GRB)), 32'h0000_FFFF);
    $display("test reset done");
    wr(32'(OFF_START), 32'h7);
    wrp(ad(0, 7'(OFF_CNT)), 32'h1000, 4);
    rdc(ad(0, 7'(OFF_CNT)), 32'h1000);
    pulse(1);
    rdc(ad(0, 7'(OFF_CNT)), 32'h1001);
    wrp(ad(0, 7'(OFF_CNT_HI)), 32'hAB, 3);
    rdc(ad(0, 7'(OFF_CNT)), 32'hAB01);
    $display("test write vs count done");
    wr(32'(OFF_MASK), 32'h4);
    wr(ad(0, 7'(OFF_CNT)), 32'hFFFF);
    pulse(1);
    rdc(ad(0, 7'(OFF_CNT)), 32'h0);
    // both compare registers still hold all ones, so A and B match as well
    rdc(32'(OFF_STAT), 32'h7);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(32'(OFF_STAT), 32'h7);
    rdc(32'(OFF_STAT), 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(32'(OFF_MASK), 32'h0);
    wr(ad(0, 7'(OFF_CNT)), 32'hFFFF);
    wrp(ad(0, 7'(OFF_CNT)), 32'h5, 4);
    rdc(ad(0, 7'(OFF_CNT)), 32'h5);
    rdc(32'(OFF_STAT), 32'h7);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test wrap done");
    wr(ad(0, 7'(OFF_GRA)), 32'h3);
    wr(ad(0, 7'(OFF_CTRL)), {30'h0, CLR_A});
    wr(ad(0, 7'(OFF_CNT)), 32'h0);
    wr(32'(OFF_STAT), 32'h1FF);
    pulse(4);
    rdc(ad(0, 7'(OFF_CNT)), 32'h0);
    rdc(32'(OFF_STAT), 32'h1);
    wr(ad(0, 7'(OFF_GRB)), 32'h1);
    wr(ad(0, 7'(OFF_CTRL)), {30'h0, CLR_B});
    wr(ad(0, 7'(OFF_CNT)), 32'h1);
    wrp(ad(0, 7'(OFF_CNT)), 32'h77, 4);
    rdc(ad(0, 7'(OFF_CNT)), 32'h0);
    wr(ad(0, 7'(OFF_CTRL)), {30'h0, CLR_NONE});
    wr(ad(0, 7'(OFF_CNT)), 32'h5);
    wr(ad(0, 7'(OFF_GRA)), 32'h5);
    wr(32'(OFF_STAT), 32'h1FF);
    wrp(ad(0, 7'(OFF_GRA)), 32'h5, 4);
    rdc(32'(OFF_STAT), 32'h0);
    rdc(ad(0, 7'(OFF_CNT)), 32'h6);
    $display("test clear and match done");
    wr(ad(0, 7'(OFF_CNT)), 32'h0);
    wr(ad(0, 7'(OFF_GRA)), 32'h1);
    wr(ad(0, 7'(OFF_GRB)), 32'h3);
    wr(32'(OFF_MODE), 32'h1);
    pulse(2);
    chk("pwm_out", {29'h0, pwm_out}, 32'h1);
    pulse(2);
    chk("pwm_out", {29'h0, pwm_out}, 32'h0);
    wr(ad(0, 7'(OFF_GRB)), 32'h5);
    wr(ad(0, 7'(OFF_GRA)), 32'h5);
    wr(32'(OFF_STAT), 32'h1FF);
    pulse(2);
    rdc(32'(OFF_STAT), 32'h0);
    chk("pwm_out", {29'h0, pwm_out}, 32'h0);
    wr(ad(0, 7'(OFF_IOCTL)), 32'h1);
    cap_a <= 3'h1;
    repeat (10) @(posedge clock);
    rdc(ad(0, 7'(OFF_GRA)), 32'h5);
    wr(32'(OFF_MODE), 32'h0);
    cap_a <= 3'h0;
    repeat (10) @(posedge clock);
    cap_a <= 3'h1;
    repeat (10) @(posedge clock);
    rdc(ad(0, 7'(OFF_GRA)), 32'h6);
    $display("test pwm and capture done");
    wr(32'(OFF_SYNC), 32'h3);
    wr(ad(1, 7'(OFF_CNT)), 32'h3300);
    wr(ad(0, 7'(OFF_CNT)), 32'h1200);
    wr(ad(0, 7'(OFF_CNT_LO)), 32'h55);
    rdc(ad(1, 7'(OFF_CNT)), 32'h1255);
    rdc(ad(0, 7'(OFF_CNT)), 32'h1255);
    $display("test sync write done");
    wr(32'(OFF_MODE), 32'h8);
    quad_b <= 1'b1;
    repeat (10) @(posedge clock);
    quad_a <= 1'b1;
    repeat (10) @(posedge clock);
    rdc(ad(2, 7'(OFF_CNT)), 32'h2);
    $display("test quadrature done");
    finish_test();
  end
endmodule
